// [rtl/wwsc_pkg.sv]
package wwsc_pkg;
    typedef enum logic [2:0] {
        mode_reset  = 3'h0,
        mode_nreq   = 3'h1,
        mode_normal = 3'h3,
        mode_stop   = 3'h2,
        mode_sleep  = 3'h6
    } wwsc_mode_t;

    // Commands carried in the mode field
    localparam logic [1:0] CMD_NORMAL = 2'h0;
    localparam logic [1:0] CMD_STOP   = 2'h1;
    localparam logic [1:0] CMD_SLEEP  = 2'h2;

    // Sensed state of the watchdog configuration pin
    localparam logic [1:0] WDCFG_RES  = 2'h0;
    localparam logic [1:0] WDCFG_GND  = 2'h1;
    localparam logic [1:0] WDCFG_OPEN = 2'h2;

    localparam int unsigned CLK_MHZ = 250;

    localparam int unsigned WDOG_NOM_MS  = 150;
    localparam int unsigned WDOG_NOM_CYC = WDOG_NOM_MS * 1000 * CLK_MHZ;
    localparam int unsigned NREQ_TMO_MS  = 150;
    localparam int unsigned NREQ_TMO_CYC = NREQ_TMO_MS * 1000 * CLK_MHZ;
    localparam int unsigned RST_PULSE_MS  = 1;
    localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned LIN_FILT_US  = 100;
    localparam int unsigned LIN_FILT_CYC = LIN_FILT_US * CLK_MHZ;
    localparam int unsigned CYC_BASE_MS  = 10;
    localparam int unsigned CYC_BASE_CYC = CYC_BASE_MS * 1000 * CLK_MHZ;
    localparam int unsigned CYC_SENSE_NS  = 4000;
    localparam int unsigned CYC_SENSE_CYC = (CYC_SENSE_NS * CLK_MHZ) / 1000;
    localparam int unsigned RST_GLITCH_NS = 100;
    localparam logic [7:0]  RST_GLITCH_CYC = 8'((RST_GLITCH_NS * CLK_MHZ + 999) / 1000);

    // Pin synchroniser: width and idle levels after reset
    localparam int unsigned  SYNC_W   = 17;
    localparam logic [16:0]  SYNC_RST = 17'h07000;
endpackage : wwsc_pkg

// [rtl/wwsc_sync.sv]
`timescale 1ns/10ps
module wwsc_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : wwsc_sync

// [rtl/wwsc_switch_drv.sv]
`timescale 1ns/10ps
module wwsc_switch_drv (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic on,
    input  wire logic pwm_en,
    input  wire logic pwm,
    input  wire logic ot,
    input  wire logic ov_shut,
    input  wire logic ctrl_wr,
    output logic      drv_q,
    output logic      ot_q
);
    logic ov_q;

    // A write only releases the latch once the fault itself is gone
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ot_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            ot_q <= ot | (ot_q & ~(ctrl_wr & ~ot));
            ov_q <= ov_shut | (ov_q & ~(ctrl_wr & ~ov_shut));
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drv_q <= 1'b0;
        end else begin
            drv_q <= on & ~ot & ~ot_q & ~ov_shut & ~ov_q & (~pwm_en | pwm);
        end
    end

    property p_pwm_follow;
        @(posedge ref_clk) disable iff (!resetn)
        (on && pwm_en && !ot && !ot_q && !ov_shut && !ov_q) |=> (drv_q == $past(pwm));
    endproperty
    a_pwm_follow: assert property (p_pwm_follow) else $error("switch does not track pwm");

    property p_ot_off;
        @(posedge ref_clk) disable iff (!resetn)
        ot |=> !drv_q && ot_q;
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("switch on during overtemp");

    property p_ot_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (ot_q && !ctrl_wr) |=> ot_q ##0 !drv_q;
    endproperty
    a_ot_hold: assert property (p_ot_hold) else $error("thermal latch released early");

    property p_ov_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (ov_shut && on) |=> !drv_q [*2];
    endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("switch on in overvoltage");
endmodule : wwsc_switch_drv

// [rtl/wwsc_ctrl.sv]
`timescale 1ns/10ps
module wwsc_ctrl #(
    parameter int unsigned WDOG_RES_CYC  = wwsc_pkg::WDOG_NOM_CYC,
    parameter int unsigned WDOG_NOM_CYC  = wwsc_pkg::WDOG_NOM_CYC,
    parameter int unsigned NREQ_TMO_CYC  = wwsc_pkg::NREQ_TMO_CYC,
    parameter int unsigned RST_PULSE_CYC = wwsc_pkg::RST_PULSE_CYC,
    parameter int unsigned LIN_FILT_CYC  = wwsc_pkg::LIN_FILT_CYC,
    parameter int unsigned CYC_BASE_CYC  = wwsc_pkg::CYC_BASE_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] switch_wake_input,
    input  wire logic       lin_rx,
    input  wire logic       cs_n,
    input  wire logic       rst_pin_in,
    output logic            rst_pin_out,
    output logic            rst_pin_oe,
    input  wire logic       direct_pwm_input,
    input  wire logic [1:0] wdog_config_pin,
    input  wire logic       hs_overtemp,
    input  wire logic       hs_open_load,
    input  wire logic       hs_cur_limit,
    input  wire logic       ls_overtemp,
    input  wire logic [1:0] ls_open_load,
    input  wire logic [1:0] ls_cur_limit,
    input  wire logic       supply_overvolt,
    input  wire logic [1:0] input_wake_enable,
    input  wire logic [1:0] amux_switch_sel,
    input  wire logic       cyclic_timer_select,
    input  wire logic [2:0] cyclic_period_sel,
    input  wire logic [1:0] wdog_presc_sel,
    input  wire logic       high_side_on,
    input  wire logic       high_switch_pwm_enable,
    input  wire logic       hs_ctrl_wr,
    input  wire logic [1:0] low_side_on,
    input  wire logic       low_one_pwm_enable,
    input  wire logic       low_two_pwm_enable,
    input  wire logic       ls_ctrl_wr,
    input  wire logic       overvoltage_shutdown_enable,
    input  wire logic       mode_wr,
    input  wire logic [1:0] mode_field,
    input  wire logic       high_switch_irq_mask,
    input  wire logic       isr_read,
    output logic [2:0]      mode_state,
    output logic            vdd_enable,
    output logic            irq_n,
    output logic            high_side_output,
    output logic            low_switch_one,
    output logic            low_switch_two,
    output logic [1:0]      wake_status_reg,
    output logic            wake_src_switch,
    output logic            wake_src_lin,
    output logic            wake_src_timer,
    output logic            hs_event,
    output logic            wdog_disabled_flag,
    output logic            wdog_cfg_fault,
    output logic            high_switch_open_flag,
    output logic            high_switch_limit_flag,
    output logic            low_one_open_flag,
    output logic            low_two_open_flag,
    output logic            low_one_limit_flag,
    output logic            low_two_limit_flag
);
    logic [wwsc_pkg::SYNC_W-1:0] pin_s;
    logic [1:0]  sw_s, cfg_s, ls_op_s, ls_cl_s, ls_drv, ls_on, ls_pwm, ls_ot_lat;
    logic        lin_s, cs_s, rst_s, pwm_s, hs_ot_s, hs_op_s, hs_cl_s, ls_ot_s, ov_s;
    wwsc_pkg::wwsc_mode_t mode_q, mode_d, wake_target;
    logic [31:0] time_cnt_q, lin_cnt_q, wd_base, wd_limit, cyc_period;
    logic [7:0]  rst_lo_cnt_q;
    logic [1:0]  sw_snap_q, elig_q;
    logic        run, lp, wd_off_q, wd_fault_q, lin_armed_q, cs_prev_q, irq_q;
    logic        wd_clr_cmd, wd_early, wd_over, nreq_tmo, cyclic, forced, cyc_end;
    logic        sense, sw_chg, sw_wake, cyc_wake, frc_wake, lin_wake, cs_wake;
    logic        ext_rst, rst_wake, irq_wake, lp_entry, hs_ot_lat, hs_ot_set, irq_set;

    wwsc_sync #(
        .W       (wwsc_pkg::SYNC_W),
        .RST_VAL (wwsc_pkg::SYNC_RST)
    ) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .d       ({switch_wake_input, lin_rx, cs_n, rst_pin_in, direct_pwm_input,
                   wdog_config_pin, hs_overtemp, hs_open_load, hs_cur_limit,
                   ls_overtemp, ls_open_load, ls_cur_limit, supply_overvolt}),
        .q       (pin_s)
    );
    assign {sw_s, lin_s, cs_s, rst_s, pwm_s, cfg_s, hs_ot_s, hs_op_s, hs_cl_s,
            ls_ot_s, ls_op_s, ls_cl_s, ov_s} = pin_s;

    assign run = (mode_q == wwsc_pkg::mode_nreq) || (mode_q == wwsc_pkg::mode_normal);
    assign lp  = (mode_q == wwsc_pkg::mode_stop) || (mode_q == wwsc_pkg::mode_sleep);

    // Watchdog window
    assign wd_base    = wd_fault_q ? WDOG_NOM_CYC : WDOG_RES_CYC;
    assign wd_limit   = wd_base << wdog_presc_sel;
    assign wd_clr_cmd = mode_wr && (mode_field == wwsc_pkg::CMD_NORMAL);
    assign wd_early   = (mode_q == wwsc_pkg::mode_normal) && !wd_off_q && wd_clr_cmd
                        && (time_cnt_q < (wd_limit >> 1));
    assign wd_over    = (mode_q == wwsc_pkg::mode_normal) && !wd_off_q
                        && (time_cnt_q >= wd_limit - 32'h1);
    assign nreq_tmo   = (mode_q == wwsc_pkg::mode_nreq)
                        && (time_cnt_q >= NREQ_TMO_CYC - 32'h1);

    // Low-power timer; the high side bit picks cyclic sense or forced wake
    assign cyclic     = cyclic_timer_select & high_side_on;
    assign forced     = cyclic_timer_select & ~high_side_on;
    assign cyc_period = CYC_BASE_CYC << cyclic_period_sel;
    assign cyc_end    = lp && (time_cnt_q == cyc_period - 32'h1);
    assign sense      = lp && cyclic
                        && (time_cnt_q >= cyc_period - wwsc_pkg::CYC_SENSE_CYC);

    // Wake sources
    assign sw_chg   = |((sw_s ^ sw_snap_q) & elig_q);
    assign sw_wake  = lp && !cyclic && sw_chg;
    assign cyc_wake = cyclic && cyc_end && sw_chg;
    assign frc_wake = forced && cyc_end;
    assign lin_wake = lp && lin_armed_q && lin_s;
    assign cs_wake  = (mode_q == wwsc_pkg::mode_stop) && cs_s && !cs_prev_q;
    assign ext_rst  = (rst_lo_cnt_q == wwsc_pkg::RST_GLITCH_CYC);
    assign rst_wake = (mode_q == wwsc_pkg::mode_stop) && ext_rst;
    assign irq_wake = sw_wake || cyc_wake || frc_wake || lin_wake;
    assign wake_target = wd_off_q ? wwsc_pkg::mode_normal : wwsc_pkg::mode_nreq;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            wwsc_pkg::mode_reset: begin
                if (time_cnt_q >= RST_PULSE_CYC - 32'h1) mode_d = wake_target;
            end
            wwsc_pkg::mode_nreq: begin
                if (ext_rst || nreq_tmo) mode_d = wwsc_pkg::mode_reset;
                else if (wd_clr_cmd) mode_d = wwsc_pkg::mode_normal;
            end
            wwsc_pkg::mode_normal: begin
                if (ext_rst || wd_early || wd_over) mode_d = wwsc_pkg::mode_reset;
                else if (mode_wr && mode_field == wwsc_pkg::CMD_STOP)
                    mode_d = wwsc_pkg::mode_stop;
                else if (mode_wr && mode_field == wwsc_pkg::CMD_SLEEP)
                    mode_d = wwsc_pkg::mode_sleep;
            end
            wwsc_pkg::mode_stop: begin
                // Stop also takes chip-select and reset-line wakes
                if (irq_wake || cs_wake || rst_wake) mode_d = wake_target;
            end
            wwsc_pkg::mode_sleep: begin
                if (irq_wake) mode_d = wwsc_pkg::mode_reset;
            end
            default: mode_d = wwsc_pkg::mode_reset;
        endcase
    end

    assign lp_entry = (mode_q == wwsc_pkg::mode_normal)
                      && ((mode_d == wwsc_pkg::mode_stop) || (mode_d == wwsc_pkg::mode_sleep));

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= wwsc_pkg::mode_reset;
        end else begin
            mode_q <= mode_d;
        end
    end

    // One counter serves reset pulse, request timeout, watchdog and low-power timer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            time_cnt_q <= 32'h0;
        end else if ((mode_d != mode_q) || cyc_end
                     || ((mode_q == wwsc_pkg::mode_normal) && wd_clr_cmd)) begin
            time_cnt_q <= 32'h0;
        end else begin
            time_cnt_q <= time_cnt_q + 32'h1;
        end
    end

    // Config pin only matters while the host is held in reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wd_off_q   <= 1'b0;
            wd_fault_q <= 1'b0;
        end else if (mode_q == wwsc_pkg::mode_reset) begin
            wd_off_q   <= (cfg_s == wwsc_pkg::WDCFG_GND);
            wd_fault_q <= (cfg_s == wwsc_pkg::WDCFG_OPEN);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sw_snap_q <= 2'h0;
            elig_q    <= 2'h0;
        end else if (lp_entry) begin
            sw_snap_q <= sw_s;
            elig_q    <= input_wake_enable & ~amux_switch_sel;
        end else if (cyc_end) begin
            sw_snap_q <= sw_s;
        end
    end

    // Own reset drive also reads back low, so the filter is idle in Reset mode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_lo_cnt_q <= 8'h0;
        end else if (!rst_s && (mode_q != wwsc_pkg::mode_reset)
                     && (mode_q != wwsc_pkg::mode_sleep)) begin
            if (!ext_rst) rst_lo_cnt_q <= rst_lo_cnt_q + 8'h1;
        end else begin
            rst_lo_cnt_q <= 8'h0;
        end
    end

    // A stuck dominant bus never produces the release edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lin_cnt_q   <= 32'h0;
            lin_armed_q <= 1'b0;
            cs_prev_q   <= 1'b1;
        end else begin
            cs_prev_q <= cs_s;
            if (lp && !lin_s) begin
                lin_cnt_q   <= lin_cnt_q + {31'h0, ~lin_armed_q};
                lin_armed_q <= lin_armed_q || (lin_cnt_q >= LIN_FILT_CYC - 32'h1);
            end else begin
                lin_cnt_q   <= 32'h0;
                lin_armed_q <= 1'b0;
            end
        end
    end

    // Sticky sources; a new event beats a simultaneous read
    assign hs_ot_set = hs_ot_s & ~hs_ot_lat;
    assign irq_set   = rst_s && (((mode_q == wwsc_pkg::mode_stop) && irq_wake)
                       || (run && hs_ot_set && high_switch_irq_mask));

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wake_src_switch <= 1'b0;
            wake_src_lin    <= 1'b0;
            wake_src_timer  <= 1'b0;
            hs_event        <= 1'b0;
            irq_q           <= 1'b0;
        end else begin
            wake_src_switch <= sw_wake | cyc_wake | (wake_src_switch & ~isr_read);
            wake_src_lin    <= lin_wake | (wake_src_lin & ~isr_read);
            wake_src_timer  <= frc_wake | (wake_src_timer & ~isr_read);
            hs_event        <= hs_ot_set | (hs_event & ~isr_read);
            irq_q           <= irq_set | (irq_q & ~isr_read);
        end
    end

    wwsc_switch_drv u_hs (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .on      (lp ? sense : (run & high_side_on)),
        .pwm_en  (run & high_switch_pwm_enable),
        .pwm     (pwm_s),
        .ot      (hs_ot_s),
        .ov_shut (ov_s & overvoltage_shutdown_enable),
        .ctrl_wr (hs_ctrl_wr),
        .drv_q   (high_side_output),
        .ot_q    (hs_ot_lat)
    );

    assign ls_on  = low_side_on & {2{run}};
    assign ls_pwm = {low_two_pwm_enable, low_one_pwm_enable} & {2{run}};

    for (genvar i = 0; i < 2; i++) begin : g_ls
        wwsc_switch_drv u_ls (
            .ref_clk (ref_clk),
            .resetn  (resetn),
            .on      (ls_on[i]),
            .pwm_en  (ls_pwm[i]),
            .pwm     (pwm_s),
            .ot      (ls_ot_s),
            .ov_shut (ov_s & overvoltage_shutdown_enable),
            .ctrl_wr (ls_ctrl_wr),
            .drv_q   (ls_drv[i]),
            .ot_q    (ls_ot_lat[i])
        );
    end
    assign low_switch_one = ls_drv[0];
    assign low_switch_two = ls_drv[1];

    // High-side thermal latch shows as both high-side flags at once; low-side latches show in no flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            high_switch_open_flag  <= 1'b0;
            high_switch_limit_flag <= 1'b0;
            low_one_open_flag      <= 1'b0;
            low_two_open_flag      <= 1'b0;
            low_one_limit_flag     <= 1'b0;
            low_two_limit_flag     <= 1'b0;
        end else begin
            high_switch_open_flag  <= hs_op_s | hs_ot_lat;
            high_switch_limit_flag <= hs_cl_s | hs_ot_lat;
            low_one_open_flag      <= ls_op_s[0];
            low_two_open_flag      <= ls_op_s[1];
            low_one_limit_flag     <= ls_cl_s[0];
            low_two_limit_flag     <= ls_cl_s[1];
        end
    end

    assign mode_state         = mode_q;
    assign vdd_enable         = (mode_q != wwsc_pkg::mode_sleep);
    assign irq_n              = ~irq_q;
    assign rst_pin_out        = 1'b0;
    assign rst_pin_oe         = (mode_q == wwsc_pkg::mode_reset);
    assign wake_status_reg    = sw_s;
    assign wdog_disabled_flag = wd_off_q;
    assign wdog_cfg_fault     = wd_fault_q;

    property p_elig_mux;
        @(posedge ref_clk) disable iff (!resetn)
        lp_entry |=> ((elig_q & $past(amux_switch_sel)) == 2'h0);
    endproperty
    a_elig_mux: assert property (p_elig_mux) else $error("mux input left as wake");

    property p_early_clear;
        @(posedge ref_clk) disable iff (!resetn)
        wd_early |=> (mode_q == wwsc_pkg::mode_reset) && rst_pin_oe;
    endproperty
    a_early_clear: assert property (p_early_clear) else $error("early clear not reset");

    property p_nreq_tmo;
        @(posedge ref_clk) disable iff (!resetn)
        ((mode_q == wwsc_pkg::mode_nreq) && (time_cnt_q == NREQ_TMO_CYC - 32'h1))
        |=> (mode_q == wwsc_pkg::mode_reset);
    endproperty
    a_nreq_tmo: assert property (p_nreq_tmo) else $error("request timeout missed");

    property p_cs_silent;
        @(posedge ref_clk) disable iff (!resetn)
        (cs_wake && !irq_wake) |=> (mode_q != wwsc_pkg::mode_stop) && !$rose(irq_q);
    endproperty
    a_cs_silent: assert property (p_cs_silent) else $error("chip-select wake wrong");

    property p_lin_edge;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(wake_src_lin) |-> $past(lin_s) && $past(lin_armed_q) && !$past(lin_s, 2);
    endproperty
    a_lin_edge: assert property (p_lin_edge) else $error("lin wake without filter");

    property p_stop_irq;
        @(posedge ref_clk) disable iff (!resetn)
        ((mode_q == wwsc_pkg::mode_stop) && irq_wake && rst_s)
        |=> irq_q && (mode_q == $past(wake_target));
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("stop wake no irq");

    property p_sleep_reset;
        @(posedge ref_clk) disable iff (!resetn)
        ((mode_q == wwsc_pkg::mode_sleep) && irq_wake) |=> rst_pin_oe ##1 rst_pin_oe;
    endproperty
    a_sleep_reset: assert property (p_sleep_reset) else $error("sleep wake no reset");

    property p_wd_off;
        @(posedge ref_clk) disable iff (!resetn)
        (mode_q == wwsc_pkg::mode_reset) |=> (wd_off_q == ($past(cfg_s) == wwsc_pkg::WDCFG_GND));
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog off flag wrong");

    c_lin_wake: cover property (@(posedge ref_clk) disable iff (!resetn) lin_wake);
    c_wd_over:  cover property (@(posedge ref_clk) disable iff (!resetn) wd_over);
    c_cyc_wake: cover property (@(posedge ref_clk) disable iff (!resetn) cyc_wake);
    c_frc_wake: cover property (@(posedge ref_clk) disable iff (!resetn) frc_wake);
endmodule : wwsc_ctrl

// [tb/wwsc_host.sv]
`timescale 1ns/10ps
module wwsc_host (
    input  wire logic rst_pin_out,
    input  wire logic rst_pin_oe,
    input  wire logic host_pull,
    output logic      rst_line
);
    // Open-drain line with pull-up: once released it reads high, never a held value
    assign rst_line = ((rst_pin_oe & ~rst_pin_out) | host_pull) ? 1'b0 : 1'b1;
endmodule : wwsc_host

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
    logic ref_clk, resetn, lin_rx, cs_n, rst_pin_in, rst_pin_out, rst_pin_oe, direct_pwm_input;
    logic hs_overtemp, hs_open_load, hs_cur_limit, ls_overtemp, supply_overvolt, host_pull;
    logic cyclic_timer_select, high_side_on, high_switch_pwm_enable, hs_ctrl_wr, ls_ctrl_wr;
    logic low_one_pwm_enable, low_two_pwm_enable, overvoltage_shutdown_enable, mode_wr;
    logic high_switch_irq_mask, isr_read, vdd_enable, irq_n, high_side_output, low_switch_one;
    logic low_switch_two, wake_src_switch, wake_src_lin, wake_src_timer, hs_event;
    logic wdog_disabled_flag, wdog_cfg_fault, high_switch_open_flag, high_switch_limit_flag;
    logic low_one_open_flag, low_two_open_flag, low_one_limit_flag, low_two_limit_flag;
    logic [1:0] switch_wake_input, wdog_config_pin, ls_open_load, ls_cur_limit, wake_status_reg;
    logic [1:0] input_wake_enable, amux_switch_sel, wdog_presc_sel, low_side_on, mode_field;
    logic [2:0] cyclic_period_sel, mode_state;
    logic [31:0] s = 32'h62;
    logic [31:0] r;
    int          num_errors = 0;
    int          comparisons = 0;
    wwsc_ctrl #(.WDOG_RES_CYC(64), .WDOG_NOM_CYC(64), .NREQ_TMO_CYC(100), .RST_PULSE_CYC(20),
        .LIN_FILT_CYC(10), .CYC_BASE_CYC(2000)) i_wwsc_ctrl (.ref_clk, .resetn,
        .switch_wake_input, .lin_rx, .cs_n, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
        .direct_pwm_input, .wdog_config_pin, .hs_overtemp, .hs_open_load, .hs_cur_limit,
        .ls_overtemp, .ls_open_load, .ls_cur_limit, .supply_overvolt, .input_wake_enable,
        .amux_switch_sel, .cyclic_timer_select, .cyclic_period_sel, .wdog_presc_sel,
        .high_side_on, .high_switch_pwm_enable, .hs_ctrl_wr, .low_side_on, .low_one_pwm_enable,
        .low_two_pwm_enable, .ls_ctrl_wr, .overvoltage_shutdown_enable, .mode_wr, .mode_field,
        .high_switch_irq_mask, .isr_read, .mode_state, .vdd_enable, .irq_n, .high_side_output,
        .low_switch_one, .low_switch_two, .wake_status_reg, .wake_src_switch, .wake_src_lin,
        .wake_src_timer, .hs_event, .wdog_disabled_flag, .wdog_cfg_fault,
        .high_switch_open_flag, .high_switch_limit_flag, .low_one_open_flag,
        .low_two_open_flag, .low_one_limit_flag, .low_two_limit_flag);
    wwsc_host i_wwsc_host (.rst_pin_out, .rst_pin_oe, .host_pull, .rst_line(rst_pin_in));
    function logic [31:0] xs;
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function logic drv(input logic on, input logic en, input logic p);
        return on & (~en | p);
    endfunction : drv
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task chk(input logic [2:0] g, input logic [2:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wm(input logic [2:0] m);
        for (int i = 0; i < 600 && mode_state !== m; i++) tick(1);
        chk(mode_state, m);
    endtask : wm
    task go(input logic [1:0] f, input logic [2:0] m);
        mode_field = f;
        mode_wr = 1;
        tick(1);
        mode_wr = 0;
        tick(1);
        wm(m);
    endtask : go
    task finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #40000;
        num_errors++;
        finish_test;
    end
    initial begin
        {resetn, direct_pwm_input, hs_overtemp, hs_open_load, hs_cur_limit, ls_overtemp,
         supply_overvolt, host_pull, cyclic_timer_select, high_side_on, high_switch_pwm_enable,
         hs_ctrl_wr, ls_ctrl_wr, low_one_pwm_enable, low_two_pwm_enable, mode_wr, isr_read,
         overvoltage_shutdown_enable, high_switch_irq_mask, switch_wake_input, wdog_config_pin,
         ls_open_load, ls_cur_limit, input_wake_enable, amux_switch_sel, low_side_on,
         mode_field, cyclic_period_sel} = '0;
        {lin_rx, cs_n, wdog_presc_sel} = 4'hf;
        tick(2);
        resetn = 1;
        wm(1);
        chk({rst_pin_oe, wdog_disabled_flag, wdog_cfg_fault}, 3'h0);
        go(0, 3);
        tick(300);
        go(0, 3);
        tick(3);
        chk(mode_state, 3);
        go(0, 0);
        wm(1);
        go(0, 3);
        for (int k = 0; k < 16; k++) begin
            r = xs();
            {high_side_on, high_switch_pwm_enable, direct_pwm_input, low_side_on,
             low_one_pwm_enable, low_two_pwm_enable} = r[6:0];
            {hs_open_load, ls_open_load, ls_cur_limit, hs_cur_limit, supply_overvolt,
             switch_wake_input} = r[15:7];
            {amux_switch_sel, input_wake_enable, high_switch_irq_mask} = r[20:16];
            tick(4);
            chk({high_side_output, low_switch_one, low_switch_two}, {drv(r[6], r[5], r[4]),
                drv(r[2], r[1], r[4]), drv(r[3], r[0], r[4])});
            chk({high_switch_open_flag, low_one_open_flag, low_two_open_flag}, {r[15], r[13], r[14]});
            chk({high_switch_limit_flag, low_one_limit_flag, low_two_limit_flag}, {r[10], r[11], r[12]});
            chk(wake_status_reg, r[8:7]);
        end
        {hs_open_load, hs_cur_limit, high_switch_pwm_enable, supply_overvolt} = '0;
        {high_side_on, high_switch_irq_mask, hs_overtemp} = 3'h7;
        tick(5);
        chk({high_side_output, hs_event, irq_n}, 3'h2);
        chk({high_switch_open_flag, high_switch_limit_flag}, 3'h3);
        hs_overtemp = 0;
        tick(5);
        chk(high_side_output, 0);
        hs_ctrl_wr = 1;
        tick(1);
        hs_ctrl_wr = 0;
        tick(4);
        chk(high_side_output, 1);
        wm(0);
        wm(1);
        isr_read = 1;
        tick(1);
        isr_read = 0;
        go(0, 3);
        go(1, 2);
        // A bus stuck dominant must not wake; only the release after it does
        lin_rx = 0;
        tick(40);
        chk(mode_state, 2);
        lin_rx = 1;
        wm(1);
        chk({wake_src_lin, irq_n, wake_src_switch}, 3'h4);
        isr_read = 1;
        tick(1);
        isr_read = 0;
        go(0, 3);
        go(1, 2);
        cs_n = 0;
        tick(3);
        cs_n = 1;
        wm(1);
        chk({irq_n, wake_src_switch, wake_src_lin}, 3'h4);
        go(0, 3);
        {low_side_on, low_one_pwm_enable, low_two_pwm_enable} = 4'hc;
        {overvoltage_shutdown_enable, supply_overvolt} = 2'h3;
        tick(5);
        chk({high_side_output, low_switch_one, low_switch_two}, 3'h0);
        {supply_overvolt, ls_overtemp} = 2'h1;
        tick(4);
        {hs_ctrl_wr, ls_ctrl_wr} = 2'h3;
        tick(1);
        {hs_ctrl_wr, ls_ctrl_wr, ls_overtemp} = 3'h0;
        tick(4);
        chk({high_side_output, low_switch_one, low_switch_two}, 3'h4);
        ls_ctrl_wr = 1;
        tick(1);
        ls_ctrl_wr = 0;
        tick(4);
        chk({high_side_output, low_switch_one, low_switch_two}, 3'h7);
        go(1, 2);
        // Held exactly as long as the reset-line filter needs
        host_pull = 1;
        tick(25);
        host_pull = 0;
        wm(1);
        chk({irq_n, wake_src_switch, wake_src_timer}, 3'h4);
        {input_wake_enable, amux_switch_sel} = 4'hd;
        go(0, 3);
        go(1, 2);
        switch_wake_input ^= 2'h1;
        tick(10);
        chk(mode_state, 2);
        switch_wake_input ^= 2'h2;
        wm(1);
        chk({irq_n, wake_src_switch}, 3'h1);
        go(0, 3);
        go(2, 6);
        chk(vdd_enable, 0);
        cs_n = 0;
        tick(3);
        cs_n = 1;
        tick(10);
        chk(mode_state, 6);
        lin_rx = 0;
        tick(14);
        lin_rx = 1;
        wm(0);
        chk({vdd_enable, wake_src_lin}, 3'h3);
        finish_test;
    end
endmodule : testbench
